// ===== rtl/sadc_ctrl.sv
// Functional notes
// RQ1: Eight-bit successive approximation with sample-and-hold.
// RQ2: Eight inputs, only the selected one converted.
// RQ3: Input at high reference gives full scale.
// RQ4: Input at low reference gives zero.
// RQ5: Conversion 64 cycles, sampling 31.5 cycles; the code samples for 32 cycles.
// RQ6: Result code is monotonic with input.
// RQ7: Ideal result is 255 times relative input.
// RQ8: Control bits 2 to 0 pick channel.
// RQ9: Power-on waits 30 us, then converts continuously.
// RQ10: Clearing power bit stops conversion.
// RQ11: Completion sets done flag and loads result.
// RQ12: Completion raises no interrupt.
// RQ13: Control write aborts, clears flag, restarts.
// RQ14: Reading result clears done flag.
// RQ15: Result read-only, eight bits wide.
// RQ16: Both registers reset to zero.
// RQ17: Control bit 4 always reads zero.
// RQ18: Software writes zero to bits 6, 3.
// RQ19: Wait mode leaves converter untouched.
// RQ20: Halt stops conversion until restarted and stabilised.
// RQ21: Software sets analog pins as plain inputs.
// RQ22: Analog pins stay readable as logic inputs.
// RQ23: Result holds until next conversion completes.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "sadc_cfg.svh"
module sadc_ctrl
#(
  parameter logic [`SADC_STAB_W-1:0] STAB_CYC = `SADC_STAB_W'(`SADC_STAB_CYC)
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SADC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_in,
  input wire logic halt_mode,
  input wire logic wait_mode,
  output logic [2:0] chan_sel,
  output logic sample_hold,
  output logic [7:0] trial_code,
  output logic analog_pwr_en
);
  sadc_eng_if eng ();

  sadc_pkg::sadc_state_t state_ff;
  sadc_pkg::sadc_state_t nxt_state;
  sadc_pkg::sadc_sel_t acc_sel;
  logic [`SADC_STAB_W-1:0] stab_cnt_ff;
  logic conversion_done_flag_ff;
  logic nxt_done_flag;
  logic converter_power_on_ff;
  logic [2:0] chan_select_ff;
  logic [7:0] conversion_result_ff;
  logic [7:0] nxt_result;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic analog_pwr_ff;
  logic cmp_meta_ff;
  logic cmp_sync_ff;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic ctrl_wr;
  logic res_rd;

  function automatic logic [`SADC_ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = `SADC_ADDR_W'({idx, 2'b00});
  endfunction

  function automatic sadc_pkg::sadc_sel_t decode
  (
    input logic [`SADC_ADDR_W-1:0] addr
  );
    if (addr == byte_addr(`SADC_IDX_RESULT))
      decode = sadc_pkg::SADC_SEL_RESULT;
    else if (addr == byte_addr(`SADC_IDX_CTRL))
      decode = sadc_pkg::SADC_SEL_CTRL;
    else
      decode = sadc_pkg::SADC_SEL_NONE;
  endfunction

  // Reserved bits 6, 4 and 3 are not stored and always read as zero.
  function automatic logic [31:0] reg_read
  (
    input sadc_pkg::sadc_sel_t sel,
    input logic flag,
    input logic pwr,
    input logic [2:0] ch,
    input logic [7:0] res
  );
    logic [7:0] ctrl;
    ctrl = `SADC_CTRL_RST;
    ctrl[`SADC_BIT_DONE] = flag;
    ctrl[`SADC_BIT_PWR] = pwr;
    ctrl[`SADC_CH_MSB:`SADC_CH_LSB] = ch;
    unique case (sel)
      sadc_pkg::SADC_SEL_RESULT: reg_read = {24'h000000, res};
      sadc_pkg::SADC_SEL_CTRL: reg_read = {24'h000000, ctrl};
      default: reg_read = 32'h00000000;
    endcase
  endfunction

  always_comb
  begin
    acc_sel = decode(paddr);
    setup = psel && !penable;
    wr_acc = psel && penable && pready_ff && pwrite;
    rd_acc = psel && penable && pready_ff && !pwrite;
    ctrl_wr = wr_acc && acc_sel == sadc_pkg::SADC_SEL_CTRL;
    res_rd = rd_acc && acc_sel == sadc_pkg::SADC_SEL_RESULT; // RQ15
  end

  // The access phase always lasts one cycle; read data is taken from the
  // values that the setup edge leaves behind.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
    else
    begin
      pready_ff <= setup && !pready_ff;
      pslverr_ff <= setup && acc_sel == sadc_pkg::SADC_SEL_NONE;
      if (setup)
        prdata_ff <= reg_read(acc_sel, nxt_done_flag, // RQ17
          converter_power_on_ff, chan_select_ff, nxt_result);
    end
  end

  // Control write; bits 6 and 3 are expected as zero and simply dropped.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      converter_power_on_ff <= 1'(`SADC_CTRL_RST >> `SADC_BIT_PWR); // RQ16
      chan_select_ff <= 3'h0; // RQ16
    end
    else if (ctrl_wr)
    begin
      converter_power_on_ff <= pwdata[`SADC_BIT_PWR]; // RQ9 RQ10
      chan_select_ff <= pwdata[`SADC_CH_MSB:`SADC_CH_LSB]; // RQ8
    end
  end

  // A completion in the same cycle as a clearing access wins, so no
  // finished result is ever silently lost.
  always_comb
  begin
    nxt_result = eng.done ? eng.result : conversion_result_ff; // RQ11 RQ23
    if (eng.done)
      nxt_done_flag = 1'b1; // RQ11 RQ12
    else if (ctrl_wr || res_rd)
      nxt_done_flag = 1'b0; // RQ13 RQ14
    else
      nxt_done_flag = conversion_done_flag_ff;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      conversion_done_flag_ff <= 1'b0; // RQ16
      conversion_result_ff <= `SADC_RESULT_RST; // RQ16
    end
    else
    begin
      conversion_done_flag_ff <= nxt_done_flag;
      conversion_result_ff <= nxt_result;
    end
  end

  // Wait mode is deliberately absent from every transition below.
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      sadc_pkg::SADC_OFF:
        if (converter_power_on_ff && !halt_mode)
          nxt_state = sadc_pkg::SADC_SETTLE; // RQ9
      sadc_pkg::SADC_SETTLE:
        if (!converter_power_on_ff)
          nxt_state = sadc_pkg::SADC_OFF;
        else if (halt_mode)
          nxt_state = sadc_pkg::SADC_HALTED;
        else if (stab_cnt_ff == STAB_CYC - 1'b1)
          nxt_state = sadc_pkg::SADC_RUN; // RQ9
      sadc_pkg::SADC_RUN:
        if (!converter_power_on_ff)
          nxt_state = sadc_pkg::SADC_OFF; // RQ10
        else if (halt_mode)
          nxt_state = sadc_pkg::SADC_HALTED; // RQ20
      sadc_pkg::SADC_HALTED:
        if (!converter_power_on_ff)
          nxt_state = sadc_pkg::SADC_OFF;
        else if (!halt_mode)
          nxt_state = sadc_pkg::SADC_SETTLE; // RQ20
      default:
        nxt_state = sadc_pkg::SADC_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      state_ff <= sadc_pkg::SADC_OFF;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      stab_cnt_ff <= '0;
    else if (state_ff != sadc_pkg::SADC_SETTLE)
      stab_cnt_ff <= '0;
    else
      stab_cnt_ff <= `SADC_STAB_W'(stab_cnt_ff + 1'b1); // RQ9 RQ20
  end

  // The comparator output is asynchronous to the clock.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cmp_meta_ff <= 1'b0;
      cmp_sync_ff <= 1'b0;
    end
    else
    begin
      cmp_meta_ff <= cmp_in;
      cmp_sync_ff <= cmp_meta_ff;
    end
  end

  // Only the mux select, the hold, the trial code and the analog power enable are driven; port input buffers are never gated, so
  // the pins keep reading as logic inputs.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      analog_pwr_ff <= 1'b0;
    else
      analog_pwr_ff <= nxt_state == sadc_pkg::SADC_SETTLE
        || nxt_state == sadc_pkg::SADC_RUN; // RQ10 RQ20 RQ22
  end

  assign eng.run = state_ff == sadc_pkg::SADC_RUN; // RQ9 RQ19
  assign eng.restart = ctrl_wr; // RQ13
  assign eng.cmp = cmp_sync_ff;

  sadc_sar u_sar
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .eng(eng)
  );

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign chan_sel = chan_select_ff; // RQ2 RQ8
  assign sample_hold = eng.sample;
  assign trial_code = eng.code;
  assign analog_pwr_en = analog_pwr_ff;

  // Checking helpers: cycles between completions of unbroken runs.
  logic [`SADC_GAP_W-1:0] gap_ff;
  logic gap_ok_ff;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gap_ff <= '0;
      gap_ok_ff <= 1'b0;
    end
    else
    begin
      gap_ff <= eng.done ? '0 : `SADC_GAP_W'(gap_ff + 1'b1);
      if (!eng.run || eng.restart)
        gap_ok_ff <= 1'b0;
      else if (eng.done)
        gap_ok_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  chk_conv_period: assert property ( // RQ5
    eng.done && gap_ok_ff |-> gap_ff == `SADC_GAP_W'(`SADC_CONV_CYC - 1))
    else $error("conversion period is not 64 cycles");

  chk_sample_phase: assert property ( // RQ5
    eng.run && !eng.restart ##1 $fell(sample_hold) ##0 eng.run
    |-> $past(sample_hold, 32) && !$past(sample_hold, 33))
    else $error("sampling phase is not 32 cycles");

  chk_done_loads: assert property ( // RQ11
    eng.done |=> conversion_done_flag_ff
      && conversion_result_ff == $past(eng.result))
    else $error("completion did not set flag and result");

  chk_result_hold: assert property ( // RQ23
    !eng.done |=> $stable(conversion_result_ff))
    else $error("result changed without a completion");

  chk_write_clears: assert property ( // RQ13
    ctrl_wr && !eng.done |=> !conversion_done_flag_ff ##1 !eng.done)
    else $error("control write did not clear and restart");

  chk_read_clears: assert property ( // RQ14
    res_rd && !eng.done |=> !conversion_done_flag_ff)
    else $error("result read did not clear the flag");

  chk_rsv_zero: assert property ( // RQ17
    rd_acc && acc_sel == sadc_pkg::SADC_SEL_CTRL
    |-> prdata[`SADC_BIT_RSV4] == 1'b0 && prdata[`SADC_BIT_RSV6] == 1'b0
      && prdata[`SADC_BIT_RSV3] == 1'b0)
    else $error("reserved control bits read nonzero");

  chk_power_off: assert property ( // RQ10
    !converter_power_on_ff |-> ##1 !eng.run ##1 !eng.done && !sample_hold)
    else $error("converter still active while powered off");

  chk_stab_wait: assert property ( // RQ9
    eng.run && !$past(eng.run)
    |-> $past(state_ff) == sadc_pkg::SADC_SETTLE
      && $past(stab_cnt_ff) == STAB_CYC - 1'b1)
    else $error("conversion began before stabilisation");

  chk_halt_stop: assert property ( // RQ20
    halt_mode |=> !eng.run ##1 !eng.done)
    else $error("conversion continued during halt");

  chk_chan_out: assert property ( // RQ8
    ctrl_wr |=> chan_sel == $past(pwdata[`SADC_CH_MSB:`SADC_CH_LSB]))
    else $error("channel select did not follow the write");

  cov_done_run: cover property (eng.done ##1 conversion_done_flag_ff);
  cov_abort: cover property (ctrl_wr && eng.run && !sample_hold);
  cov_halt_resume: cover property ($fell(halt_mode) ##[1:8] eng.run);
  cov_wait_done: cover property (wait_mode && eng.done);
  cov_read_flag: cover property (res_rd && conversion_done_flag_ff);
endmodule // sadc_ctrl

// ===== inc/sadc_cfg.svh
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define SADC_IDX_RESULT 8'h0a
`define SADC_IDX_CTRL 8'h0b
`define SADC_ADDR_W 12

// Reset values, full-scale result and first trial code.
`define SADC_CTRL_RST 8'h00
`define SADC_RESULT_RST 8'h00
`define SADC_RESULT_FULL 8'hff
`define SADC_TRIAL_MSB 8'h80

// Control and status field positions.
`define SADC_BIT_DONE 7
`define SADC_BIT_RSV6 6
`define SADC_BIT_PWR 5
`define SADC_BIT_RSV4 4
`define SADC_BIT_RSV3 3
`define SADC_CH_MSB 2
`define SADC_CH_LSB 0

// Conversion timing in clock cycles.
`define SADC_CONV_CYC 64
`define SADC_SAMPLE_HALF_CYC 63
`define SADC_SAMPLE_CYC ((`SADC_SAMPLE_HALF_CYC + 1) / 2)
`define SADC_RES_BITS 8
`define SADC_BIT_CYC ((`SADC_CONV_CYC - `SADC_SAMPLE_CYC) / `SADC_RES_BITS)
`define SADC_CNT_W 6
`define SADC_GAP_W 7

// Stabilisation time after power-on or after leaving halt.
`define SADC_CLK_MHZ 250
`define SADC_STAB_US 30
`define SADC_STAB_CYC (`SADC_STAB_US * `SADC_CLK_MHZ)
`define SADC_STAB_W 13

`endif

// ===== inc/sadc_pkg.sv
package sadc_pkg;

  typedef enum logic [3:0]
  {
    SADC_OFF = 4'b0001,
    SADC_SETTLE = 4'b0010,
    SADC_RUN = 4'b0100,
    SADC_HALTED = 4'b1000
  } sadc_state_t;

  typedef enum logic [1:0]
  {
    SADC_SEL_NONE = 2'h0,
    SADC_SEL_RESULT = 2'h1,
    SADC_SEL_CTRL = 2'h2
  } sadc_sel_t;

endpackage

// ===== inc/sadc_eng_if.sv
`timescale 1ns/1ps
interface sadc_eng_if;
  logic run;
  logic restart;
  logic cmp;
  logic done;
  logic sample;
  logic [7:0] result;
  logic [7:0] code;

  modport ctrl
  (
    output run,
    output restart,
    output cmp,
    input done,
    input sample,
    input result,
    input code
  );

  modport engine
  (
    input run,
    input restart,
    input cmp,
    output done,
    output sample,
    output result,
    output code
  );
endinterface

// ===== rtl/sadc_sar.sv
`timescale 1ns/1ps
`include "sadc_cfg.svh"
module sadc_sar
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  sadc_eng_if.engine eng
);
  logic [`SADC_CNT_W-1:0] cnt_ff;
  logic [`SADC_CNT_W-1:0] nxt_cnt;
  logic [`SADC_CNT_W-1:0] ofs;
  logic [7:0] code_ff;
  logic [7:0] result_ff;
  logic done_ff;
  logic sample_ff;
  logic armed_ff;
  logic [2:0] bidx;
  logic in_bits;
  logic last_ph;
  logic go;

  always_comb
  begin
    go = eng.run && !eng.restart;
    nxt_cnt = (go && armed_ff) ? `SADC_CNT_W'(cnt_ff + 1'b1) : '0;
    ofs = `SADC_CNT_W'(cnt_ff - `SADC_CNT_W'(`SADC_SAMPLE_CYC));
    in_bits = cnt_ff >= `SADC_CNT_W'(`SADC_SAMPLE_CYC);
    bidx = 3'(`SADC_RES_BITS - 1) - 3'(ofs / `SADC_CNT_W'(`SADC_BIT_CYC));
    last_ph = (ofs % `SADC_CNT_W'(`SADC_BIT_CYC))
      == `SADC_CNT_W'(`SADC_BIT_CYC - 1);
  end

  // The counter width equals one conversion, so it wraps straight into the
  // next sample phase and conversions follow back to back.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt; // RQ5
  end

  // One idle cycle after every start lets the hold signal rise together
  // with the first counted cycle, so no sampling phase is cut short.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      armed_ff <= 1'b0;
    else
      armed_ff <= go; // RQ5
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      sample_ff <= 1'b0;
    else
      sample_ff <= go && nxt_cnt < `SADC_CNT_W'(`SADC_SAMPLE_CYC); // RQ1 RQ5
  end

  // A bit is kept when the input is at or above the trial level, so a
  // saturated input keeps every bit and a grounded one keeps none.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      code_ff <= '0;
    else if (!go)
      code_ff <= '0;
    else if (cnt_ff == `SADC_CNT_W'(`SADC_SAMPLE_CYC - 1))
      code_ff <= `SADC_TRIAL_MSB; // RQ1
    else if (in_bits && last_ph)
    begin
      code_ff[bidx] <= eng.cmp; // RQ3 RQ4 RQ6 RQ7
      if (bidx != 3'h0)
        code_ff[3'(bidx - 3'h1)] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      done_ff <= 1'b0;
      result_ff <= `SADC_RESULT_RST;
    end
    else
    begin
      done_ff <= go && cnt_ff == `SADC_CNT_W'(`SADC_CONV_CYC - 1);
      if (go && cnt_ff == `SADC_CNT_W'(`SADC_CONV_CYC - 1))
        result_ff <= {code_ff[7:1], eng.cmp}; // RQ1
    end
  end

  assign eng.code = code_ff;
  assign eng.sample = sample_ff;
  assign eng.done = done_ff;
  assign eng.result = result_ff;
endmodule // sadc_sar

// ===== tb/sadc_analog_src.sv
`timescale 1ns/1ps
module sadc_analog_src
(
  input wire logic clk_sys,
  input wire logic [63:0] levels,
  input wire logic [2:0] chan_sel,
  input wire logic [7:0] trial_code,
  input wire logic analog_pwr_en,
  output logic cmp_in
);
  logic junk_ff = 1'b0;

  // An unpowered comparator gives no usable answer, so it toggles.
  always @(posedge clk_sys)
  begin
    junk_ff <= ~junk_ff;
  end

  // Pins are plain inputs with no pull-up; the mux picks one level.
  assign cmp_in = analog_pwr_en ?
    (levels[chan_sel*8 +: 8] >= trial_code) : junk_ff;
endmodule // sadc_analog_src

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "sadc_cfg.svh"
module testbench;
  localparam int stab_cyc = 20;
  localparam logic [11:0] a_res = {2'h0, `SADC_IDX_RESULT, 2'h0};
  localparam logic [11:0] a_ctl = {2'h0, `SADC_IDX_CTRL, 2'h0};
  logic clk_sys = 1'b0;
  logic sys_rst, psel, penable, pwrite, cmp_in, halt_mode, wait_mode;
  logic pready, pslverr, sample_hold, analog_pwr_en, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] chan_sel;
  logic [7:0] trial_code, lvl;
  logic [63:0] levels;
  int err_total = 0;
  int checked = 0;
  int seed, n, h, i;

  always #2 clk_sys = ~clk_sys;

  sadc_ctrl #(.STAB_CYC(13'(stab_cyc))) sadc_ctrl_i
  (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_in(cmp_in), .halt_mode(halt_mode),
    .wait_mode(wait_mode), .chan_sel(chan_sel),
    .sample_hold(sample_hold), .trial_code(trial_code),
    .analog_pwr_en(analog_pwr_en)
  );

  sadc_analog_src sadc_analog_src_i
  (
    .clk_sys(clk_sys), .levels(levels), .chan_sel(chan_sel),
    .trial_code(trial_code), .analog_pwr_en(analog_pwr_en),
    .cmp_in(cmp_in)
  );

  function automatic logic [7:0] sar_code(input logic [7:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int b = 7; b >= 0; b--)
      if (v >= (c | (8'h01 << b))) c[b] = 1'b1;
    return c;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    chk({31'h0, k < 16}, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wait_on();
    n = 0;
    while (sample_hold !== 1'b1 && n < 500)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, n >= stab_cyc - 1 && n <= stab_cyc + 6}, 32'h1);
  endtask

  task automatic wait_done();
    int k;
    k = 0;
    q = 32'h0;
    while (q[7] !== 1'b1 && k < 100)
    begin
      apb(1'b0, a_ctl, 32'h0);
      k++;
    end
    chk({31'h0, q[7]}, 32'h1);
  endtask

  initial
  begin
    seed = 32'h4f9c;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    halt_mode = 1'b0;
    wait_mode = 1'b0;
    levels = 64'h0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, a_res, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, a_ctl, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, a_ctl, 32'ha5a5_00b0);
    wait_on();
    apb(1'b0, a_ctl, 32'h0);
    chk(q, 32'h20);
    // Sampling phase length and conversion period, back to back; the
    // first conversion is still sampling, so skip to the next one.
    n = 0;
    while (sample_hold === 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    while (sample_hold !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    h = 0;
    while (sample_hold === 1'b1 && h < 100)
    begin
      @(posedge clk_sys);
      h++;
    end
    n = h;
    while (sample_hold !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(h), 32'd32);
    chk(32'(n), 32'd64);
    for (i = 0; i < 8; i++)
    begin
      lvl = (i == 0) ? 8'hff : (i == 7) ? 8'h00 : 8'($random(seed));
      levels[i*8 +: 8] <= lvl;
      wait_mode <= 1'($random(seed));
      apb(1'b1, a_ctl, 32'h20 | 32'(i));
      chk({29'h0, chan_sel}, 32'(i));
      apb(1'b0, a_ctl, 32'h0);
      chk(q, 32'h20 | 32'(i));
      wait_done();
      apb(1'b0, a_res, 32'h0);
      chk(q, {24'h0, sar_code(lvl)});
      apb(1'b0, a_ctl, 32'h0);
      chk(q, 32'h20 | 32'(i));
    end
    halt_mode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({31'h0, analog_pwr_en}, 32'h0);
    halt_mode <= 1'b0;
    wait_on();
    wait_done();
    apb(1'b0, a_res, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, a_ctl, 32'h07);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, analog_pwr_en}, 32'h0);
    apb(1'b1, a_res, 32'hff);
    chk({31'h0, e}, 32'h0);
    apb(1'b0, a_res, 32'h0);
    chk(q, 32'h0);
    repeat (150) @(posedge clk_sys);
    apb(1'b0, a_ctl, 32'h0);
    chk(q, 32'h07);
    print_verdict();
  end

  // Whole run is about a thousand cycles; this limit of 40000 cycles is nearly forty times that.
  initial
  begin
    #160000;
    err_total++;
    print_verdict();
  end
endmodule // testbench
